// *** dv/loop_detect_watchdog_bench.sv ***
// self-checking bench for the loop-detect watchdog
`timescale 1ns/100ps
module loop_detect_watchdog_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] div = 4'h0;
    logic stab = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rst_req;
    logic nmi_req;
    logic clk_sw;
    logic irq;
    logic [31:0] rd;
    logic [31:0] c0;
    logic err;
    logic [2:0] s;
    int fails = 0;
    int samples_checked = 0;
    int n;

    loop_detect_watchdog dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .internal_osc_clk(div[3]), .main_clk(div[1]),
        .sub_clk(div[2]), .osc_stab_busy(stab), .overflow_reset_req(rst_req),
        .overflow_nmi_req(nmi_req), .cpu_clk_to_osc(clk_sw), .irq(irq));

    // pclk and the divided source clocks
    always #2 pclk = ~pclk;
    always @(posedge pclk) div <= div + 4'h1;

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        // an idle edge first, so a release and the next request never share a step
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // collect overflow requests over a number of cycles
    task automatic watch(input int cyc);
        s = 3'h0;
        repeat (cyc) begin
            @(posedge pclk);
            s = s | {clk_sw, nmi_req, rst_req};
        end
    endtask

    task automatic do_reset;
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask

    task automatic t_defaults;
        apb(1'b0, 8'h00, 32'h0);
        check("mode reset", 32'h67, rd);
        apb(1'b0, 8'h04, 32'h0);
        check("restart read", 32'h9a, rd);
        apb(1'b0, 8'h18, 32'h0);
        c0 = rd;
        repeat (40) @(posedge pclk);
        apb(1'b0, 8'h18, 32'h0);
        check("counting", 32'h1, {31'h0, rd > c0});
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped error", 32'h1, {31'h0, err});
        apb(1'b1, 8'h04, 32'hac);
        apb(1'b0, 8'h18, 32'h0);
        check("count after key", 32'h1, {31'h0, rd < 32'h2});
        $display("done defaults");
    endtask

    task automatic t_forced;
        apb(1'b1, 8'h10, 32'h2);
        apb(1'b1, 8'h04, 32'h11);
        watch(3);
        check("bad key request", 32'h1, {29'h0, s});
        check("irq set", 32'h1, {31'h0, irq});
        apb(1'b0, 8'h0c, 32'h0);
        check("status forced", 32'h2, rd & 32'h2);
        apb(1'b1, 8'h0c, 32'h2);
        @(posedge pclk);
        check("irq cleared", 32'h0, {31'h0, irq});
        apb(1'b1, 8'h10, 32'h0);
        apb(1'b1, 8'h08, 32'h0);
        watch(3);
        check("bit access request", 32'h1, {29'h0, s});
        check("irq masked", 32'h0, {31'h0, irq});
        stab <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b1, 8'h04, 32'h55);
        watch(3);
        check("clock switch", 32'h4, {29'h0, s});
        stab <= 1'b0;
        repeat (4) @(posedge pclk);
        $display("done forced");
    endtask

    // wait for an nmi request, counting cycles
    task automatic wait_nmi;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (nmi_req !== 1'b1 && n < 6000);
        if (n >= 6000) begin
            fails++;
            finish_test();
        end
    endtask

    task automatic t_nmi;
        apb(1'b1, 8'h00, 32'h30);
        wait_nmi();
        wait_nmi();
        check("subclock period", 32'd4096, n);
        apb(1'b1, 8'h00, 32'h67);
        watch(3);
        check("second mode write", 32'h2, {29'h0, s});
        apb(1'b0, 8'h00, 32'h0);
        check("mode kept", 32'h30, rd);
        $display("done nmi");
    endtask

    task automatic t_stopped;
        do_reset();
        apb(1'b1, 8'h00, 32'h00);
        apb(1'b1, 8'h04, 32'h11);
        watch(3);
        check("stopped bad key", 32'h0, {29'h0, s});
        apb(1'b1, 8'h00, 32'h67);
        watch(20);
        check("stopped quiet", 32'h0, {29'h0, s});
        apb(1'b0, 8'h18, 32'h0);
        check("stopped count", 32'h0, rd);
        $display("done stopped");
    endtask

    // main clock source, one count per main clock period over 44 edges
    task automatic t_main;
        do_reset();
        apb(1'b1, 8'h00, 32'h28);
        apb(1'b0, 8'h18, 32'h0);
        c0 = rd;
        repeat (40) @(posedge pclk);
        apb(1'b0, 8'h18, 32'h0);
        check("main clock ticks", 32'd11, rd - c0);
        $display("done main");
    endtask

    initial begin
        do_reset();
        t_defaults();
        t_forced();
        t_nmi();
        t_stopped();
        t_main();
        finish_test();
    end
endmodule // loop_detect_watchdog_bench

// *** dv/wdt_checker.sv ***
// port assertions for the loop-detect watchdog
`timescale 1ns/100ps
module wdt_checker (
    // apb side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    // overflow requests
    input wire logic overflow_reset_req,
    input wire logic overflow_nmi_req,
    input wire logic cpu_clk_to_osc
);
    logic [1:0] mode_q;
    logic seen_q;
    logic wr;
    logic ovf;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // completed write and any overflow request
    assign wr = psel && penable && pready && pwrite;
    assign ovf = overflow_reset_req || overflow_nmi_req || cpu_clk_to_osc;
    // shadow of the mode field, only the first write after reset lands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= 2'h3;
            seen_q <= 1'b0;
        end else if (wr && paddr == 8'h00 && !seen_q) begin
            mode_q <= pwdata[6:5];
            seen_q <= 1'b1;
        end
    end
    one_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered after one wait");
    restart_read_a: assert property (
        pready && !pwrite && paddr == 8'h04 |-> prdata == 32'h9a) else $error("restart read");
    rst_pulse_a: assert property (
        overflow_reset_req |=> !overflow_reset_req) else $error("reset request too long");
    nmi_pulse_a: assert property (
        overflow_nmi_req |=> !overflow_nmi_req) else $error("nmi request too long");
    nmi_mode_a: assert property (
        overflow_nmi_req |-> mode_q == 2'h1) else $error("nmi request outside nmi mode");
    bad_key_a: assert property (
        wr && paddr == 8'h04 && pwdata[7:0] != 8'hac && mode_q != 2'h0 |=> ovf)
        else $error("bad key gave no overflow");
    bit_access_a: assert property (
        wr && paddr == 8'h08 && mode_q != 2'h0 |=> ovf) else $error("bit access no overflow");
    second_mode_a: assert property (
        wr && paddr == 8'h00 && seen_q && mode_q != 2'h0 |=> ovf)
        else $error("second mode write no overflow");
    stopped_quiet_a: assert property (
        mode_q == 2'h0 && $stable(mode_q) |-> !ovf) else $error("overflow while stopped");
endmodule // wdt_checker

bind loop_detect_watchdog wdt_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .overflow_reset_req(overflow_reset_req),
    .overflow_nmi_req(overflow_nmi_req), .cpu_clk_to_osc(cpu_clk_to_osc));

// *** hdl/loop_detect_watchdog.sv ***
// loop-detect watchdog with apb registers, three source clocks and forced overflow
// Notes on behaviour
// - interval field picks oscillator, main or subclock and a power-of-two period.
// - key byte ac hex to restart register clears counter and restarts.
// - any other restart value forces an overflow at once.
// - single-bit access to restart register forces overflow unless stopped; normal access is byte.
// - restart register resets to 9a hex and always reads 9a hex.
// - second mode write forces overflow and clears the counter.
// - in stopped mode, bad keys and second mode writes cause no overflow.
// - after reset the watchdog counts in reset mode with no software help.
// - once an active mode is written, nothing can stop the watchdog.
// - expiry without key raises reset request or nmi request per mode bits.
// - reset-mode overflow during stabilisation switches cpu clock, no reset.
// - writing 00 hex as the first mode write after reset stops the watchdog.
// - mode 00 stop, 01 nmi on overflow, 1x reset on overflow.
// - mode register resets to 67 hex: reset mode, oscillator, 2^19 period.
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
module loop_detect_watchdog (
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // source clock pins
    input wire logic internal_osc_clk,
    input wire logic main_clk,
    input wire logic sub_clk,
    // oscillation stabilisation in progress
    input wire logic osc_stab_busy,
    // overflow requests
    output logic overflow_reset_req,
    output logic overflow_nmi_req,
    output logic cpu_clk_to_osc,
    // interrupt
    output logic irq
);
    // register state
    logic [6:0] wd_mode_reg_q;
    logic mode_written_q;
    logic [wdt_pkg::CNT_W-1:0] count_q;
    logic [wdt_pkg::ST_W-1:0] status_q;
    logic [wdt_pkg::ST_W-1:0] status_d;
    logic [wdt_pkg::ST_W-1:0] mask_q;

    // synchronised stabilisation flag
    logic stab_meta_q;
    logic stab_q;

    // apb response registers
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;

    // overflow request and interrupt registers
    logic reset_req_q;
    logic nmi_req_q;
    logic osc_sw_q;
    logic irq_q;

    // source ticks, read path and field decode
    logic [wdt_pkg::NSRC-1:0] ticks;
    logic [31:0] rd_data;
    logic rd_hit;
    logic [1:0] mode_bits;
    logic [1:0] src_bits;
    logic running;
    logic reset_mode;

    // period select and counter control
    logic tick_sel;
    logic [4:0] shift;
    logic [wdt_pkg::CNT_W-1:0] last_count;
    logic count_clr;

    // bus write decode
    logic acc_fire;
    logic wr_fire;
    logic wr_mode;
    logic wr_restart;
    logic wr_bitacc;
    logic wr_status;
    logic wr_mask;
    logic first_mode;

    // overflow events
    logic good_key;
    logic bad_key;
    logic mode_rewrite;
    logic bad_write;
    logic nat_ovf;
    logic forced_ovf;
    logic any_ovf;
    logic osc_sw_ev;

    // source clock synchronisers, one per selectable clock
    tick_if tk [wdt_pkg::NSRC] (.pclk(pclk), .presetn(presetn));
    assign tk[wdt_pkg::SRC_OSC].pin = internal_osc_clk;
    assign tk[wdt_pkg::SRC_MAIN].pin = main_clk;
    assign tk[wdt_pkg::SRC_SUB].pin = sub_clk;
    genvar gi;
    generate
        for (gi = 0; gi < wdt_pkg::NSRC; gi++) begin : g_src
            src_tick_sync u_sync (
                .tk(tk[gi].sync)
            );
            assign ticks[gi] = tk[gi].tick;
        end
    endgenerate

    // stabilisation flag passes two flops before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stab_meta_q <= 1'b0;
            stab_q <= 1'b0;
        end else begin
            stab_meta_q <= osc_stab_busy;
            stab_q <= stab_meta_q;
        end
    end

    // mode field decode
    assign mode_bits = wd_mode_reg_q[wdt_pkg::MODE_HI:wdt_pkg::MODE_LO];
    assign src_bits = wd_mode_reg_q[wdt_pkg::SRC_HI:wdt_pkg::SRC_LO];
    assign running = (mode_bits != 2'b00);
    assign reset_mode = mode_bits[1];

    always_comb begin
        if (src_bits[1]) begin
            tick_sel = ticks[wdt_pkg::SRC_SUB];
            shift = wdt_pkg::SUB_BASE;
        end else if (src_bits[0]) begin
            tick_sel = ticks[wdt_pkg::SRC_MAIN];
            shift = wdt_pkg::MAIN_BASE;
        end else begin
            tick_sel = ticks[wdt_pkg::SRC_OSC];
            shift = wdt_pkg::OSC_BASE;
        end
        shift = shift + {2'b00, wd_mode_reg_q[wdt_pkg::EXP_HI:0]};
    end

    // count value at which the period ends
    assign last_count = (wdt_pkg::CNT_W'(1) << shift) - wdt_pkg::CNT_W'(1);

    // apb access decode, effects land at the edge pready is sampled high
    assign acc_fire = psel & penable & pready_q;
    assign wr_fire = acc_fire & pwrite;
    assign wr_mode = wr_fire & (paddr == wdt_pkg::MODE_OFS);
    assign wr_restart = wr_fire & (paddr == wdt_pkg::RESTART_OFS);
    assign wr_bitacc = wr_fire & (paddr == wdt_pkg::BITACC_OFS);
    assign wr_status = wr_fire & (paddr == wdt_pkg::STATUS_OFS);
    assign wr_mask = wr_fire & (paddr == wdt_pkg::MASK_OFS);
    assign first_mode = wr_mode & ~mode_written_q;

    assign good_key = wr_restart & (pwdata[7:0] == wdt_pkg::RESTART_KEY);

    assign bad_key = wr_restart & ~good_key;

    assign mode_rewrite = wr_mode & mode_written_q;

    // bit access, wrong key or mode rewrite are improper writes
    assign bad_write = bad_key | wr_bitacc | mode_rewrite;

    assign forced_ovf = running & bad_write;

    assign nat_ovf = running & tick_sel & (count_q == last_count) & ~good_key;
    assign any_ovf = nat_ovf | forced_ovf;

    // overflow while stabilising in reset mode
    assign osc_sw_ev = any_ovf & reset_mode & stab_q;

    // mode register, one write after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_mode_reg_q <= wdt_pkg::MODE_RST;
        end else if (first_mode) begin
            wd_mode_reg_q <= pwdata[6:0];
        end
    end

    // write-once flag, later mode writes are refused
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_written_q <= 1'b0;
        end else if (first_mode) begin
            mode_written_q <= 1'b1;
        end
    end

    // counter clear: stopped, key, any overflow or the first mode write
    assign count_clr = ~running | good_key | any_ovf | first_mode;

    // counter, restarts on key, overflow or the first mode write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= '0;
        end else if (count_clr) begin
            count_q <= '0;
        end else if (tick_sel) begin
            count_q <= count_q + wdt_pkg::CNT_W'(1);
        end
    end

    // one-cycle reset request, held back while stabilising
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_req_q <= 1'b0;
        end else begin
            reset_req_q <= any_ovf & reset_mode & ~stab_q;
        end
    end

    // one-cycle nmi request in nmi mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nmi_req_q <= 1'b0;
        end else begin
            nmi_req_q <= any_ovf & (mode_bits == 2'b01);
        end
    end

    // clock switch instead of a reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_sw_q <= 1'b0;
        end else begin
            osc_sw_q <= osc_sw_ev;
        end
    end

    // sticky status, a new event wins over a write-one clear
    always_comb begin
        status_d = status_q;
        if (wr_status) begin
            status_d = status_d & ~pwdata[wdt_pkg::ST_W-1:0];
        end
        if (nat_ovf) begin
            status_d[wdt_pkg::ST_NAT] = 1'b1;
        end
        if (forced_ovf) begin
            status_d[wdt_pkg::ST_FORCED] = 1'b1;
        end
        if (osc_sw_ev) begin
            status_d[wdt_pkg::ST_OSCSW] = 1'b1;
        end
    end

    // sticky status register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= '0;
        end else begin
            status_q <= status_d;
        end
    end

    // interrupt mask, same layout as status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= '0;
        end else if (wr_mask) begin
            mask_q <= pwdata[wdt_pkg::ST_W-1:0];
        end
    end

    // level interrupt, follows status and a mask write at the same edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_d & (wr_mask ? pwdata[wdt_pkg::ST_W-1:0] : mask_q));
        end
    end

    // read data mux
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit = 1'b1;
        case (paddr)
            wdt_pkg::MODE_OFS: rd_data = {25'h000_0000, wd_mode_reg_q};
            wdt_pkg::RESTART_OFS: rd_data = {24'h00_0000, wdt_pkg::RESTART_READ};
            wdt_pkg::BITACC_OFS: rd_data = {24'h00_0000, wdt_pkg::RESTART_READ};
            wdt_pkg::STATUS_OFS: rd_data = {29'h0000_0000, status_q};
            wdt_pkg::MASK_OFS: rd_data = {29'h0000_0000, mask_q};
            wdt_pkg::STATE_OFS: rd_data = {29'h0000_0000, stab_q, running, mode_written_q};
            wdt_pkg::COUNT_OFS: rd_data = {6'h00, count_q};
            default: rd_hit = 1'b0;
        endcase
    end

    // apb ready: one wait cycle, then a one-cycle pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= psel & penable & ~pready_q;
        end
    end

    // error flag for an unmapped address, alongside pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_q <= 1'b0;
        end else begin
            pslverr_q <= psel & penable & ~pready_q & ~rd_hit;
        end
    end

    // read data, valid only in the pready cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && penable && !pready_q && !pwrite && rd_hit) begin
            prdata_q <= rd_data;
        end else begin
            prdata_q <= 32'h0000_0000;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign overflow_reset_req = reset_req_q;
    assign overflow_nmi_req = nmi_req_q;
    assign cpu_clk_to_osc = osc_sw_q;
    assign irq = irq_q;
endmodule // loop_detect_watchdog

// *** hdl/src_tick_sync.sv ***
// synchroniser and rising-edge detector for one source clock pin
`timescale 1ns/100ps
module src_tick_sync (
    tick_if.sync tk
);
    logic meta_q;
    logic sync_q;
    logic prev_q;
    logic tick_q;

    // two flops then edge detect, one pclk pulse per source rising edge
    always_ff @(posedge tk.pclk or negedge tk.presetn) begin
        if (!tk.presetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            meta_q <= tk.pin;
            sync_q <= meta_q;
            prev_q <= sync_q;
            tick_q <= sync_q & ~prev_q;
        end
    end

    assign tk.tick = tick_q;
endmodule // src_tick_sync

// *** hdl/tick_if.sv ***
// interface carrying one source clock pin and its pclk-domain tick
`timescale 1ns/100ps
interface tick_if (
    input wire logic pclk,
    input wire logic presetn
);
    logic pin;
    logic tick;
    modport sync (input pclk, input presetn, input pin, output tick);
    modport user (output pin, input tick);
endinterface

// *** hdl/wdt_pkg.sv ***
// constants shared by the loop-detect watchdog files
package wdt_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] MODE_OFS = 8'h00;
    localparam logic [7:0] RESTART_OFS = 8'h04;
    localparam logic [7:0] BITACC_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0c;
    localparam logic [7:0] MASK_OFS = 8'h10;
    localparam logic [7:0] STATE_OFS = 8'h14;
    localparam logic [7:0] COUNT_OFS = 8'h18;
    // reset values and key bytes
    localparam logic [6:0] MODE_RST = 7'h67;
    localparam logic [7:0] RESTART_KEY = 8'hac;
    localparam logic [7:0] RESTART_READ = 8'h9a;
    // mode register fields
    localparam int MODE_HI = 6;
    localparam int MODE_LO = 5;
    localparam int SRC_HI = 4;
    localparam int SRC_LO = 3;
    localparam int EXP_HI = 2;
    // overflow period exponents per source clock
    localparam logic [4:0] OSC_BASE = 5'h0c;
    localparam logic [4:0] MAIN_BASE = 5'h12;
    localparam logic [4:0] SUB_BASE = 5'h09;
    localparam int CNT_W = 26;
    // source clock indices
    localparam int SRC_OSC = 0;
    localparam int SRC_MAIN = 1;
    localparam int SRC_SUB = 2;
    localparam int NSRC = 3;
    // status bit positions
    localparam int ST_NAT = 0;
    localparam int ST_FORCED = 1;
    localparam int ST_OSCSW = 2;
    localparam int ST_W = 3;
endpackage
